// *** logic/ats_pkg.sv ***
/*
  Constants, register map and carrier types of the conversion trigger sequencer.
  Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
`default_nettype none
package ats_pkg;
  // word indices; byte address is four times the index
  localparam int ATS_IDX_CTRL = 0;
  localparam int ATS_IDX_MON0 = 1;
  localparam int ATS_IDX_MON1 = 2;
  localparam int ATS_IDX_FLAGS = 3;
  localparam int ATS_IDX_RES = 4;
  localparam int ATS_IDX_PSEL = 16;
  localparam int ATS_IDX_PINTS = 22;
  localparam int ATS_IDX_PSET = 28;
  localparam int ATS_IDX_TSET = 34;
  localparam int ATS_IDX_SSET = 37;
  localparam int ATS_IDX_ASET = 40;
  localparam int ATS_NWORDS = 43;

  localparam int ATS_NUM_RES = 12;
  localparam int ATS_NUM_LINES = 6;
  localparam int ATS_NUM_PROGS = 6;
  localparam logic [3:0] ATS_LAST_MOTOR_SLOT = 4'h3;
  localparam logic [3:0] ATS_LAST_TABLE_SLOT = 4'hb;

  // control word fields
  localparam int ATS_CTRL_EN_BIT = 0;
  localparam int ATS_CTRL_SWSTART_BIT = 1;
  localparam int ATS_CTRL_CONST_BIT = 2;
  localparam int ATS_CTRL_BUSY_BIT = 4;
  localparam int ATS_CTRL_SRC_LSB = 5;
  // monitor word fields
  localparam int ATS_MON_EN_BIT = 0;
  localparam int ATS_MON_SENSE_BIT = 1;
  localparam int ATS_MON_IDX_LSB = 2;
  localparam int ATS_MON_CMP_LSB = 16;
  // program entry byte: [4:0] input, [7] enable
  localparam int ATS_ENTRY_EN_BIT = 7;
  // program interrupt select word
  localparam int ATS_PINTS_SEL_BIT = 0;
  localparam int ATS_PINTS_EN_BIT = 1;
  localparam int ATS_FLAGS_OVR_LSB = 16;

  localparam logic [31:0] ATS_WORD_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ATS_SRC_MOTOR,
    ATS_SRC_TIMER,
    ATS_SRC_SW,
    ATS_SRC_CONST
  } ats_src_t;

  typedef enum logic [1:0] {
    ATS_IDLE,
    ATS_PICK,
    ATS_WAIT
  } ats_state_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic [4:0] chan;
  } ats_conv_req_t;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } ats_conv_res_t;
endpackage : ats_pkg
`default_nettype wire

// *** logic/ats_sequencer.sv ***
/*
  Conversion trigger sequencer: arbitrates motor, timer, software and constant
  programs, drives an external converter, stores results, runs two monitors.
  Assumes the converter, triggers and bus all share clk_i; the converter answers
  a start with one done pulse no earlier than the cycle after the start.
*/
// Notes on behaviour
// - start programs on software, motor or timer request
// - higher-priority trigger abandons running program
// - motor trigger waits for running motor program
// - each monitor works only when enabled
// - monitor match raises its own interrupt
// - compare in the result write cycle
// - monitor leaves stored flag alone
// - monitor is no read; overrun still sets
// - software interrupt after all enabled slots
// - disable aborts conversion, result not written
// - unread result overwritten sets overrun flag
// - newer result replaces older one
// - reading a result clears its overrun
// - motor trigger halts software conversion at once
// - preempted software program restarts at slot zero
// - timer trigger preempts software likewise
// - motor slots in order, then completion interrupt
// - table entry m writes result m if enabled
// - motor slots store results 0 to 3
// - each motor line starts its selected program
// - each motor program selects its completion interrupt
`timescale 1ns/100ps
`default_nettype none
module ats_sequencer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] motor_trigger_line_i,
  input wire logic timer_trigger_irq_i,
  output ats_pkg::ats_conv_req_t conv_req_o,
  input wire ats_pkg::ats_conv_res_t conv_res_i,
  output logic monitor0_irq_o,
  output logic monitor1_irq_o,
  output logic software_conv_done_irq_o,
  output logic timer_conv_done_irq_o,
  output logic [1:0] motor_prog_done_irq_o
);
  logic [ats_pkg::ATS_NWORDS-1:0][31:0] cfg_q;
  logic [11:0] res_q [ats_pkg::ATS_NUM_RES];
  logic [ats_pkg::ATS_NUM_RES-1:0] stored_q;
  logic [ats_pkg::ATS_NUM_RES-1:0] ovr_q;
  logic [ats_pkg::ATS_NUM_RES-1:0] rd_clr;
  logic [ats_pkg::ATS_NUM_RES-1:0] wr_hit;
  logic ack_q;
  logic [31:0] dat_q;
  ats_pkg::ats_state_t state_q;
  ats_pkg::ats_src_t cur_src_q;
  logic [3:0] slot_q;
  logic [2:0] prog_q;
  logic [5:0] motor_pend_q;
  logic timer_pend_q;
  logic sw_pend_q;
  ats_pkg::ats_conv_req_t req_q;
  logic [1:0] mon_irq_q;
  logic sw_irq_q;
  logic tmr_irq_q;
  logic [1:0] mot_irq_q;

  // bus decode
  wire logic bus_req = wb_cyc_i & wb_stb_i;
  wire logic bus_done = bus_req & ack_q;
  wire logic wr_en = bus_done & wb_we_i;
  wire logic [5:0] adr_idx = wb_adr_i[7:2];
  int unsigned adr_word;
  assign adr_word = 32'(adr_idx);
  wire logic cfg_wr_ok = (adr_word <= 32'(ats_pkg::ATS_IDX_MON1))
                       | ((adr_word >= 32'(ats_pkg::ATS_IDX_PSEL))
                          & (adr_word < 32'(ats_pkg::ATS_NWORDS)));
  wire logic [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] cur_word = cfg_wr_ok ? cfg_q[adr_idx] : ats_pkg::ATS_WORD_RST;
  // start bit is a strobe, never kept in the stored word
  wire logic [31:0] strobe_mask =
    (adr_word == 32'(ats_pkg::ATS_IDX_CTRL)) ? ~(32'h1 << ats_pkg::ATS_CTRL_SWSTART_BIT)
                                             : 32'hffff_ffff;
  wire logic [31:0] merged = ((cur_word & ~byte_mask) | (wb_dat_i & byte_mask)) & strobe_mask;
  wire logic sw_start = wr_en & (adr_word == 32'(ats_pkg::ATS_IDX_CTRL)) & wb_sel_i[0]
                      & wb_dat_i[ats_pkg::ATS_CTRL_SWSTART_BIT];

  wire logic conv_en = cfg_q[ats_pkg::ATS_IDX_CTRL][ats_pkg::ATS_CTRL_EN_BIT];
  wire logic const_en = cfg_q[ats_pkg::ATS_IDX_CTRL][ats_pkg::ATS_CTRL_CONST_BIT];

  // arbitration
  logic [2:0] pick_line;
  always_comb begin
    pick_line = 3'h0;
    for (int l = ats_pkg::ATS_NUM_LINES - 1; l >= 0; l--) begin
      if (motor_pend_q[l]) begin
        pick_line = 3'(l);
      end
    end
  end

  ats_pkg::ats_src_t hi_src;
  wire logic hi_valid = (|motor_pend_q) | timer_pend_q | sw_pend_q | const_en;
  assign hi_src = (|motor_pend_q) ? ats_pkg::ATS_SRC_MOTOR :
                  timer_pend_q ? ats_pkg::ATS_SRC_TIMER :
                  sw_pend_q ? ats_pkg::ATS_SRC_SW : ats_pkg::ATS_SRC_CONST;
  wire logic running = (state_q != ats_pkg::ATS_IDLE);
  // equal priority never preempts, so a motor program runs to its end
  wire logic preempt = running & hi_valid & (hi_src < cur_src_q);
  wire logic launch = conv_en & hi_valid & (~running | preempt);
  wire logic [2:0] psel_raw = cfg_q[ats_pkg::ATS_IDX_PSEL + 32'(pick_line)][2:0];
  // program numbers above five fall back to program zero
  wire logic [2:0] psel_val = (psel_raw < 3'(ats_pkg::ATS_NUM_PROGS)) ? psel_raw : 3'h0;

  // current program entry
  int unsigned tbl_idx;
  always_comb begin
    case (cur_src_q)
      ats_pkg::ATS_SRC_MOTOR: tbl_idx = ats_pkg::ATS_IDX_PSET + 32'(prog_q);
      ats_pkg::ATS_SRC_TIMER: tbl_idx = ats_pkg::ATS_IDX_TSET + 32'(slot_q[3:2]);
      ats_pkg::ATS_SRC_SW: tbl_idx = ats_pkg::ATS_IDX_SSET + 32'(slot_q[3:2]);
      default: tbl_idx = ats_pkg::ATS_IDX_ASET + 32'(slot_q[3:2]);
    endcase
  end
  wire logic [31:0] tbl_word = cfg_q[tbl_idx];
  wire logic [7:0] entry = tbl_word[8 * slot_q[1:0] +: 8];
  wire logic entry_en = entry[ats_pkg::ATS_ENTRY_EN_BIT];
  wire logic is_motor = (cur_src_q == ats_pkg::ATS_SRC_MOTOR);
  wire logic last_slot = slot_q == (is_motor ? ats_pkg::ATS_LAST_MOTOR_SLOT
                                             : ats_pkg::ATS_LAST_TABLE_SLOT);
  wire logic conv_fin = (state_q == ats_pkg::ATS_WAIT) & conv_res_i.done;
  wire logic slot_end = ((state_q == ats_pkg::ATS_PICK) & ~entry_en) | conv_fin;
  wire logic prog_done = conv_en & slot_end & last_slot;
  // result lands only while enabled; slot number is the result index
  wire logic wr_res = conv_en & conv_fin;
  wire logic issue = conv_en & ~preempt & (state_q == ats_pkg::ATS_PICK) & entry_en;
  wire logic do_abort = (state_q == ats_pkg::ATS_WAIT) & ~conv_res_i.done
                      & (preempt | ~conv_en);
  wire logic sw_repend = preempt & ~prog_done & (cur_src_q == ats_pkg::ATS_SRC_SW);
  wire logic clr_timer = launch & (hi_src == ats_pkg::ATS_SRC_TIMER);
  wire logic clr_sw = launch & (hi_src == ats_pkg::ATS_SRC_SW);
  wire logic [5:0] clr_motor = (launch & (hi_src == ats_pkg::ATS_SRC_MOTOR))
                             ? (6'h1 << pick_line) : 6'h0;
  wire logic [1:0] pints = cfg_q[ats_pkg::ATS_IDX_PINTS + 32'(prog_q)][1:0];

  // read mux
  logic [31:0] rd_data;
  always_comb begin
    rd_data = ats_pkg::ATS_WORD_RST;
    if (adr_word == 32'(ats_pkg::ATS_IDX_CTRL)) begin
      rd_data = cfg_q[ats_pkg::ATS_IDX_CTRL];
      rd_data[ats_pkg::ATS_CTRL_BUSY_BIT] = running;
      rd_data[ats_pkg::ATS_CTRL_SRC_LSB +: 2] = cur_src_q;
    end else if (adr_word == 32'(ats_pkg::ATS_IDX_FLAGS)) begin
      rd_data[ats_pkg::ATS_NUM_RES-1:0] = stored_q;
      rd_data[ats_pkg::ATS_FLAGS_OVR_LSB +: ats_pkg::ATS_NUM_RES] = ovr_q;
    end else if ((adr_word >= 32'(ats_pkg::ATS_IDX_RES))
                 & (adr_word < 32'(ats_pkg::ATS_IDX_PSEL))) begin
      rd_data[11:0] = res_q[adr_word - 32'(ats_pkg::ATS_IDX_RES)];
    end else if (cfg_wr_ok) begin
      rd_data = cfg_q[adr_idx];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= ats_pkg::ATS_WORD_RST;
      cfg_q <= '0;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q) begin
        dat_q <= rd_data;
      end
      if (wr_en & cfg_wr_ok) begin
        cfg_q[adr_idx] <= merged;
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // result registers and their flags
  for (genvar m = 0; m < ats_pkg::ATS_NUM_RES; m++) begin : g_res
    assign wr_hit[m] = wr_res & (slot_q == 4'(m));
    assign rd_clr[m] = bus_done & ~wb_we_i & (adr_word == 32'(ats_pkg::ATS_IDX_RES + m));
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        res_q[m] <= 12'h000;
        stored_q[m] <= 1'b0;
        ovr_q[m] <= 1'b0;
      end else begin
        if (wr_hit[m]) begin
          res_q[m] <= conv_res_i.data;
        end
        // a new result beats a read in the same cycle
        stored_q[m] <= wr_hit[m] | (stored_q[m] & ~rd_clr[m]);
        ovr_q[m] <= (wr_hit[m] & stored_q[m]) | (ovr_q[m] & ~rd_clr[m]);
      end
    end
  end

  // monitors look at the incoming value, so a match costs no bus read
  for (genvar i = 0; i < 2; i++) begin : g_mon
    wire logic [31:0] mon_word = cfg_q[ats_pkg::ATS_IDX_MON0 + i];
    wire logic [11:0] mon_cmp = mon_word[ats_pkg::ATS_MON_CMP_LSB +: 12];
    wire logic mon_ge = conv_res_i.data >= mon_cmp;
    wire logic mon_sense = mon_word[ats_pkg::ATS_MON_SENSE_BIT];
    wire logic mon_sel = wr_res & (slot_q == mon_word[ats_pkg::ATS_MON_IDX_LSB +: 4]);
    wire logic mon_hit = mon_word[ats_pkg::ATS_MON_EN_BIT] & mon_sel
                       & (mon_sense ? mon_ge : ~mon_ge);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        mon_irq_q[i] <= 1'b0;
      end else begin
        mon_irq_q[i] <= mon_hit;
      end
    end
  end
  assign monitor0_irq_o = mon_irq_q[0];
  assign monitor1_irq_o = mon_irq_q[1];

  // pending requests: a new trigger beats the clear of its own bit
  always_ff @(posedge clk_i) begin
    if (rst_i | ~conv_en) begin
      motor_pend_q <= 6'h00;
      timer_pend_q <= 1'b0;
      sw_pend_q <= 1'b0;
    end else begin
      motor_pend_q <= (motor_pend_q & ~clr_motor) | motor_trigger_line_i;
      timer_pend_q <= (timer_pend_q & ~clr_timer) | timer_trigger_irq_i;
      sw_pend_q <= (sw_pend_q & ~clr_sw) | sw_start | sw_repend;
    end
  end

  // sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ats_pkg::ATS_IDLE;
      cur_src_q <= ats_pkg::ATS_SRC_CONST;
      slot_q <= 4'h0;
      prog_q <= 3'h0;
    end else if (~conv_en) begin
      state_q <= ats_pkg::ATS_IDLE;
    end else if (launch) begin
      state_q <= ats_pkg::ATS_PICK;
      cur_src_q <= hi_src;
      slot_q <= 4'h0;
      if (hi_src == ats_pkg::ATS_SRC_MOTOR) begin
        prog_q <= psel_val;
      end
    end else begin
      case (state_q)
        ats_pkg::ATS_PICK: begin
          if (entry_en) begin
            state_q <= ats_pkg::ATS_WAIT;
          end else if (last_slot) begin
            state_q <= ats_pkg::ATS_IDLE;
          end else begin
            slot_q <= slot_q + 4'h1;
          end
        end
        ats_pkg::ATS_WAIT: begin
          if (conv_res_i.done) begin
            state_q <= last_slot ? ats_pkg::ATS_IDLE : ats_pkg::ATS_PICK;
            slot_q <= last_slot ? slot_q : slot_q + 4'h1;
          end
        end
        default: state_q <= ats_pkg::ATS_IDLE;
      endcase
    end
  end

  // converter command and completion pulses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= '0;
      sw_irq_q <= 1'b0;
      tmr_irq_q <= 1'b0;
      mot_irq_q <= 2'h0;
    end else begin
      req_q.start <= issue;
      req_q.abort <= do_abort;
      req_q.chan <= entry[4:0];
      sw_irq_q <= prog_done & (cur_src_q == ats_pkg::ATS_SRC_SW);
      tmr_irq_q <= prog_done & (cur_src_q == ats_pkg::ATS_SRC_TIMER);
      mot_irq_q <= (prog_done & is_motor & pints[ats_pkg::ATS_PINTS_EN_BIT])
                   ? (2'h1 << pints[ats_pkg::ATS_PINTS_SEL_BIT]) : 2'h0;
    end
  end
  assign conv_req_o = req_q;
  assign software_conv_done_irq_o = sw_irq_q;
  assign timer_conv_done_irq_o = tmr_irq_q;
  assign motor_prog_done_irq_o = mot_irq_q;
endmodule : ats_sequencer
`default_nettype wire

// *** tb/ats_conv_model.sv ***
/*
  Behavioural converter on the far side of the sequencer.
  Assumes start and abort pulses on one shared clock; answer delay set by lat_i.
*/
`timescale 1ns/100ps
`default_nettype none
module ats_conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] lat_i,
  input wire ats_pkg::ats_conv_req_t req_i,
  output ats_pkg::ats_conv_res_t res_o
);
  logic [4:0] chan_q;
  logic [3:0] cnt_q;
  logic busy_q;
  // result depends on channel only: inputs held steady
  always_ff @(posedge clk_i) begin
    res_o.done <= 1'b0;
    if (rst_i) begin
      busy_q <= 1'b0;
      res_o <= '0;
    end else if (req_i.start) begin
      busy_q <= 1'b1;
      chan_q <= req_i.chan;
      cnt_q <= lat_i;
    end else if (req_i.abort) begin
      busy_q <= 1'b0;
    end else if (busy_q && cnt_q == 4'h0) begin
      busy_q <= 1'b0;
      res_o <= {1'b1, chan_q, 7'h2b};
    end else begin
      // data toggles outside done so a stale value never matches
      cnt_q <= cnt_q - 4'h1;
      res_o.data <= ~res_o.data;
    end
  end
endmodule : ats_conv_model
`default_nettype wire

// *** tb/ats_sequencer_monitor.sv ***
/*
  Port checker for the trigger sequencer.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ats_sequencer_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire ats_pkg::ats_conv_req_t conv_req_o,
  input wire ats_pkg::ats_conv_res_t conv_res_i,
  input wire logic monitor0_irq_o,
  input wire logic monitor1_irq_o,
  input wire logic software_conv_done_irq_o,
  input wire logic [1:0] motor_prog_done_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence mirq_s;
    motor_prog_done_irq_o != 2'h0;
  endsequence
  ack_latency_a: assert property (bus_req_s |=> wb_ack_o)
    else $error("bus ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus ack without request");
  start_pulse_a: assert property (conv_req_o.start |=> !conv_req_o.start)
    else $error("start pulse too long");
  mon0_timing_a: assert property (monitor0_irq_o |-> $past(conv_res_i.done))
    else $error("monitor 0 irq not at result write");
  mon1_timing_a: assert property (monitor1_irq_o |-> $past(conv_res_i.done))
    else $error("monitor 1 irq not at result write");
  sw_irq_pulse_a: assert property (software_conv_done_irq_o |=> !software_conv_done_irq_o)
    else $error("software irq too long");
  motor_irq_a: assert property (mirq_s |-> $onehot(motor_prog_done_irq_o) ##1
    (motor_prog_done_irq_o == 2'h0))
    else $error("motor irq not a single one-hot pulse");
endmodule : ats_sequencer_monitor
bind ats_sequencer ats_sequencer_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .conv_req_o(conv_req_o),
  .conv_res_i(conv_res_i), .monitor0_irq_o(monitor0_irq_o), .monitor1_irq_o(monitor1_irq_o),
  .software_conv_done_irq_o(software_conv_done_irq_o),
  .motor_prog_done_irq_o(motor_prog_done_irq_o));
`default_nettype wire

// *** tb/ats_sequencer_tb.sv ***
/*
  Self-checking bench for the trigger sequencer.
  Assumes the converter model answers lat plus two cycles after each start.
*/
`timescale 1ns/100ps
`default_nettype none
module ats_sequencer_tb;
  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] wd;
    logic [31:0] ex;
  } ats_row_t;
  logic clk_i, rst_i, cyc, stb, we, tmr, ack, m0, m1, swi, tmi;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, x;
  logic [5:0] mot;
  logic [3:0] lat;
  logic [39:0] chs;
  logic [1:0] mirq;
  logic [7:0] ev;
  ats_pkg::ats_conv_req_t req;
  ats_pkg::ats_conv_res_t res;
  int cnt [8];
  int err_count, n_tests, b;
  ats_row_t rows [10];
  ats_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .motor_trigger_line_i(mot), .timer_trigger_irq_i(tmr),
    .conv_req_o(req), .conv_res_i(res), .monitor0_irq_o(m0), .monitor1_irq_o(m1),
    .software_conv_done_irq_o(swi), .timer_conv_done_irq_o(tmi),
    .motor_prog_done_irq_o(mirq));
  ats_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat), .req_i(req), .res_o(res));
  assign ev = {req.start, req.abort, mirq, tmi, swi, m1, m0};
  always @(posedge clk_i) begin
    for (int k = 0; k < 8; k++) cnt[k] <= cnt[k] + int'(ev[k]);
    if (req.start) chs <= {chs[34:0], req.chan};
  end
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, idx, 2'b00, d};
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 100);
    x = rdat;
    {cyc, stb} <= 2'b00;
    if (t >= 100) err_count++;
  endtask : bus
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(x, exp);
  endtask : rd
  task automatic wait_for(input int k, input int n);
    int t;
    t = 0;
    while (cnt[k] < n && t < 3000) begin
      @(posedge clk_i);
      t++;
    end
    check(cnt[k] >= n, 1);
  endtask : wait_for
  task automatic pulse(input logic [5:0] l, input logic tm);
    @(posedge clk_i);
    {mot, tmr} <= {l, tm};
    @(posedge clk_i);
    {mot, tmr} <= '0;
  endtask : pulse
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run;
  end
  initial begin
    rst_i = 1'b1;
    // timer line pulsed only when its program is in use
    {cyc, stb, we, tmr, mot, lat, adr, wdat} = '0;
    rows = '{'{6'd18, 32'h3, 32'h3}, '{6'd25, 32'h3, 32'h3},
      '{6'd31, 32'h8483, 32'h8483}, '{6'd37, 32'h8b8a89, 32'h8b8a89},
      '{6'd34, 32'h8c, 32'h8c}, '{6'd1, 32'h04ab0003, 32'h04ab0003},
      '{6'd2, 32'ha, 32'ha}, '{6'd3, 32'hffffffff, 32'h0},
      '{6'd50, 32'h1234, 32'h0}, '{6'd9, 32'hfff, 32'h0}};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(6'd3, 32'h0);
    rd(6'd4, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].idx, rows[i].wd);
      rd(rows[i].idx, rows[i].ex);
    end
    bus(1'b1, 6'd0, 32'h1);
    bus(1'b1, 6'd0, 32'h3);
    wait_for(2, 1);
    check(cnt[0], 1);
    check(cnt[1], 0);
    rd(6'd3, 32'h7);
    rd(6'd5, 32'h52b);
    rd(6'd3, 32'h5);
    bus(1'b1, 6'd0, 32'h3);
    wait_for(2, 2);
    rd(6'd3, 32'h00050007);
    rd(6'd4, 32'h4ab);
    rd(6'd3, 32'h00040006);
    // slow converter so triggers land mid-conversion
    lat <= 4'hf;
    b = cnt[7];
    bus(1'b1, 6'd0, 32'h3);
    wait_for(7, b + 1);
    pulse(6'h04, 1'b0);
    wait_for(7, b + 2);
    pulse(6'h04, 1'b0);
    wait_for(2, 3);
    check(chs, {5'd9, 5'd3, 5'd4, 5'd3, 5'd4, 5'd9, 5'd10, 5'd11});
    check({cnt[5][7:0], cnt[4][7:0], cnt[6][7:0]}, {8'd2, 8'd0, 8'd1});
    b = cnt[7];
    bus(1'b1, 6'd0, 32'h3);
    wait_for(7, b + 1);
    pulse(6'h00, 1'b1);
    wait_for(2, 4);
    // last eight starts: tail of the earlier software run, then the timer preemption
    check(chs, {5'd9, 5'd10, 5'd11, 5'd9, 5'd12, 5'd9, 5'd10, 5'd11});
    check({cnt[3][7:0], cnt[0][7:0]}, {8'd1, 8'd5});
    rd(6'd4, 32'h4ab);
    b = cnt[7];
    bus(1'b1, 6'd0, 32'h3);
    wait_for(7, b + 1);
    bus(1'b1, 6'd0, 32'h0);
    repeat (20) @(posedge clk_i);
    check({cnt[6][7:0], cnt[2][7:0]}, {8'd3, 8'd4});
    bus(1'b0, 6'd3, 32'h0);
    check(x[0], 1'b0);
    // constant program on result 0; second monitor on the below-compare sense
    bus(1'b1, 6'd40, 32'h89);
    bus(1'b1, 6'd2, 32'h05000001);
    b = cnt[7];
    bus(1'b1, 6'd0, 32'h5);
    wait_for(7, b + 3);
    // disable before the third result can land
    bus(1'b1, 6'd0, 32'h0);
    bus(1'b0, 6'd3, 32'h0);
    check({x[16], x[0]}, 2'b11);
    check(cnt[1], 2);
    rd(6'd4, 32'h4ab);
    bus(1'b0, 6'd3, 32'h0);
    check(x[16], 1'b0);
    complete_run;
  end
endmodule : ats_sequencer_tb
`default_nettype wire
